/* File: hdl/fmsp_pkg.sv */
// Purpose: Shared constants and types for the four-mode serial port.
// Assumes: 100 MHz i_clock; port clock equals i_clock.
// Notes: Register offsets are byte addresses on the plain register port.
// Function
// - Mode field 00 in high control bits 7:6 selects synchronous shift mode.
// - Data address write loads transmit buffer; read returns separate receive buffer.
// - Next byte may arrive before read; unread held byte then gets overwritten.
// - Any write to the data address starts a transmission in every mode.
// - Mode 0 reception starts only when receive pending is zero and enable set.
// - Modes 1-3 reception starts on a low start bit with receive enabled.
// - Reset clears both control registers to zero.
// - Mode 0 sets receive pending after the eighth bit shifts in.
// - Mode 1 sets receive pending at stop bit midpoint.
// - Modes 2 and 3 set receive pending at ninth bit midpoint.
// - Pending flags are cleared only by software, never by hardware.
// - Mode 0 sets transmit pending after the eighth bit shifts out.
// - Modes 1-3 set transmit pending at the start of the stop bit.
// - Modes 0, 1, 3 rate is port clock over sixteen times divisor plus one.
// - Mode 2 rate is port clock over sixteen, divisor ignored.
// - Mode 0 drives shift clock on transmit pin, data on receive pin.
// - Mode 0 moves eight bits, least significant first.
// - High bit 1 enables receive interrupt, low bit 1 enables transmit interrupt.
// - A set pending flag with its enable raises an interrupt request.
// - Low control bits 3:2 select the port clock source.
// - Low bit 7 enables transmit parity generation; software clears it for modes 0, 1.
// - Mode 01 is 8-bit async, 10 fixed-rate 9-bit, 11 variable-rate 9-bit.
// - Async 8-bit frame: low start, eight data bits LSB first, high stop.
// - Ninth transmit bit from high bit 3, received ninth bit into bit 2.
// - Multiprocessor enable in 9-bit modes blocks interrupt when ninth bit is zero.
package fmsp_pkg;
  localparam logic [7:0] ADDR_CTRL_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CTRL_LOW = 8'h15;
  localparam logic [7:0] ADDR_DATA = 8'h16;
  localparam logic [7:0] ADDR_BAUD = 8'h17;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  // High control bit positions
  localparam int H_MODE_HI = 7;
  localparam int H_MODE_LO = 6;
  localparam int H_MCE = 5;
  localparam int H_RE = 4;
  localparam int H_TB8 = 3;
  localparam int H_RB8 = 2;
  localparam int H_RIE = 1;
  localparam int H_RIP = 0;
  // Low control bit positions
  localparam int L_PAR = 7;
  localparam int L_CLK_HI = 3;
  localparam int L_CLK_LO = 2;
  localparam int L_TIE = 1;
  localparam int L_TIP = 0;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] LAST_DATA = 4'h7;
  localparam logic [3:0] NINTH = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] SCK_FALL = 4'h0;
  localparam logic [3:0] SCK_RISE = 4'h8;
  typedef enum logic [1:0] {
    FMSP_MODE_SHIFT = 2'b00,
    FMSP_MODE_A8 = 2'b01,
    FMSP_MODE_A9_FIX = 2'b10,
    FMSP_MODE_A9_VAR = 2'b11
  } fmsp_mode_t;
  typedef enum logic [2:0] {
    FMSP_TX_IDLE = 3'b000,
    FMSP_TX_START = 3'b001,
    FMSP_TX_DATA = 3'b010,
    FMSP_TX_NINTH = 3'b011,
    FMSP_TX_STOP = 3'b100,
    FMSP_TX_SHIFT = 3'b101
  } fmsp_tx_st_t;
  typedef enum logic [2:0] {
    FMSP_RX_IDLE = 3'b000,
    FMSP_RX_START = 3'b001,
    FMSP_RX_DATA = 3'b010,
    FMSP_RX_NINTH = 3'b011,
    FMSP_RX_STOP = 3'b100,
    FMSP_RX_SHIFT = 3'b101
  } fmsp_rx_st_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fmsp_bus_t;
  typedef struct packed {
    logic [7:0] div;
    logic tick;
  } fmsp_baud_t;
  typedef struct packed {
    logic s1;
    logic s2;
  } fmsp_sync_t;
endpackage

/* File: hdl/fmsp_sync.sv */
// Purpose: Two flip-flop synchroniser for the receive pin.
// Assumes: Input is asynchronous to i_clock.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ns
module fmsp_sync (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Level
  input wire logic i_async,
  output logic o_sync
);
  fmsp_pkg::fmsp_sync_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_async;
    st_next.s2 = st_reg.s1;
  end
  // Idle line is high, so reset to one to avoid a false start
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_sync = st_reg.s2;
endmodule // fmsp_sync

/* File: hdl/fmsp_baud.sv */
// Purpose: Sixteen-times tick generator.
// Assumes: Port clock is i_clock.
// Notes: Tick is one cycle every divisor plus one clocks, or every clock when i_fixed is set.
`timescale 1ns/1ns
module fmsp_baud (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Setting
  input wire logic i_fixed,
  input wire logic [7:0] i_divisor,
  // Tick
  output logic o_tick
);
  fmsp_pkg::fmsp_baud_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (i_fixed) begin
      st_next.div = 8'h00;
      st_next.tick = 1'b1;
    end else if (st_reg.div >= i_divisor) begin
      st_next.div = 8'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.div = st_reg.div + 8'h01;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_tick = st_reg.tick;
endmodule // fmsp_baud

/* File: hdl/fmsp_port.sv */
// Purpose: Four-mode serial port with register port and serial pins.
// Assumes: Single 100 MHz clock; port clock source bits stored only.
// Notes: Shift clock and data outputs are registered.
`timescale 1ns/1ns
module fmsp_port (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Serial pins
  input wire logic i_serial_rx_pin,
  output logic o_serial_rx_pin,
  output logic o_serial_rx_pin_oe,
  output logic o_serial_tx_pin,
  // Interrupt requests
  output logic o_rx_irq,
  output logic o_tx_irq,
  // Port clock source selection
  output logic [1:0] o_clock_select
);
  typedef struct packed {
    logic [7:0] ctrl_high;
    logic [7:0] ctrl_low;
    logic [7:0] baud_divisor;
    logic [7:0] rx_buf;
    logic [7:0] rdata;
    fmsp_pkg::fmsp_tx_st_t tx_st;
    logic [3:0] tx_ovs;
    logic [3:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_out;
    logic sck;
    fmsp_pkg::fmsp_rx_st_t rx_st;
    logic [3:0] rx_ovs;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_ninth;
    logic rx_oe;
    logic rx_dout;
  } fmsp_state_t;

  fmsp_state_t st_reg, st_next;
  logic rx_in;
  logic tick;
  fmsp_pkg::fmsp_bus_t bus;
  fmsp_pkg::fmsp_mode_t mode;
  logic data_wr;

  // ==========================================================
  // Input synchroniser and rate generator
  fmsp_sync u_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async(i_serial_rx_pin),
    .o_sync(rx_in)
  );

  fmsp_baud u_baud (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_fixed(mode == fmsp_pkg::FMSP_MODE_A9_FIX),
    .i_divisor(st_reg.baud_divisor),
    .o_tick(tick)
  );

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign mode = fmsp_pkg::fmsp_mode_t'(
    st_reg.ctrl_high[fmsp_pkg::H_MODE_HI:fmsp_pkg::H_MODE_LO]);
  assign data_wr = bus.wr && (bus.addr == fmsp_pkg::ADDR_DATA);

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    // Registers; software writes may clear pending flags
    if (bus.wr) begin
      case (bus.addr)
        fmsp_pkg::ADDR_CTRL_HIGH: st_next.ctrl_high = bus.wdata;
        fmsp_pkg::ADDR_CTRL_LOW: st_next.ctrl_low = bus.wdata;
        // Transmit buffer is the shift register, so a write mid-frame restarts it
        fmsp_pkg::ADDR_DATA: st_next.tx_sh = bus.wdata;
        fmsp_pkg::ADDR_BAUD: st_next.baud_divisor = bus.wdata;
        default: st_next.rdata = st_reg.rdata;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        fmsp_pkg::ADDR_CTRL_HIGH: st_next.rdata = st_reg.ctrl_high;
        fmsp_pkg::ADDR_CTRL_LOW: st_next.rdata = st_reg.ctrl_low;
        fmsp_pkg::ADDR_DATA: st_next.rdata = st_reg.rx_buf;
        fmsp_pkg::ADDR_BAUD: st_next.rdata = st_reg.baud_divisor;
        default: st_next.rdata = 8'h00;
      endcase
    end else begin
      st_next.rdata = 8'h00;
    end

    // ==========================================================
    // Transmitter
    if (data_wr) begin
      st_next.tx_ovs = 4'h0;
      st_next.tx_bit = fmsp_pkg::BIT_ZERO;
      st_next.tx_par = 1'b0;
      if (mode == fmsp_pkg::FMSP_MODE_SHIFT) begin
        st_next.tx_st = fmsp_pkg::FMSP_TX_SHIFT;
        st_next.rx_oe = 1'b1;
        st_next.rx_dout = bus.wdata[0];
      end else begin
        st_next.tx_st = fmsp_pkg::FMSP_TX_START;
        st_next.tx_out = 1'b0;
      end
    end else if (tick) begin
      st_next.tx_ovs = st_reg.tx_ovs + 4'h1;
      case (st_reg.tx_st)
        fmsp_pkg::FMSP_TX_IDLE: begin
          st_next.tx_ovs = 4'h0;
        end
        fmsp_pkg::FMSP_TX_SHIFT: begin
          // Shift clock low half then high half of each bit
          if (st_reg.tx_ovs == fmsp_pkg::SCK_FALL) begin
            st_next.sck = 1'b0;
          end else if (st_reg.tx_ovs == fmsp_pkg::SCK_RISE) begin
            st_next.sck = 1'b1;
          end
          if (st_reg.tx_ovs == fmsp_pkg::OVS_LAST) begin
            st_next.tx_sh = {1'b0, st_reg.tx_sh[7:1]};
            st_next.rx_dout = st_reg.tx_sh[1];
            st_next.tx_bit = st_reg.tx_bit + 4'h1;
            if (st_reg.tx_bit == fmsp_pkg::LAST_DATA) begin
              st_next.tx_st = fmsp_pkg::FMSP_TX_IDLE;
              st_next.rx_oe = 1'b0;
              st_next.ctrl_low[fmsp_pkg::L_TIP] = 1'b1;
            end
          end
        end
        fmsp_pkg::FMSP_TX_START: begin
          if (st_reg.tx_ovs == fmsp_pkg::OVS_LAST) begin
            st_next.tx_st = fmsp_pkg::FMSP_TX_DATA;
            st_next.tx_out = st_reg.tx_sh[0];
          end
        end
        fmsp_pkg::FMSP_TX_DATA: begin
          if (st_reg.tx_ovs == fmsp_pkg::OVS_LAST) begin
            st_next.tx_par = st_reg.tx_par ^ st_reg.tx_sh[0];
            st_next.tx_sh = {1'b0, st_reg.tx_sh[7:1]};
            st_next.tx_bit = st_reg.tx_bit + 4'h1;
            st_next.tx_out = st_reg.tx_sh[1];
            if (st_reg.tx_bit == fmsp_pkg::LAST_DATA) begin
              if (mode == fmsp_pkg::FMSP_MODE_A8) begin
                st_next.tx_st = fmsp_pkg::FMSP_TX_STOP;
                st_next.tx_out = 1'b1;
                st_next.ctrl_low[fmsp_pkg::L_TIP] = 1'b1;
              end else begin
                st_next.tx_st = fmsp_pkg::FMSP_TX_NINTH;
                // Parity replaces the programmed ninth bit when enabled
                st_next.tx_out = st_reg.ctrl_low[fmsp_pkg::L_PAR] ?
                  (st_reg.tx_par ^ st_reg.tx_sh[0]) : st_reg.ctrl_high[fmsp_pkg::H_TB8];
              end
            end
          end
        end
        fmsp_pkg::FMSP_TX_NINTH: begin
          if (st_reg.tx_ovs == fmsp_pkg::OVS_LAST) begin
            st_next.tx_st = fmsp_pkg::FMSP_TX_STOP;
            st_next.tx_out = 1'b1;
            st_next.ctrl_low[fmsp_pkg::L_TIP] = 1'b1;
          end
        end
        fmsp_pkg::FMSP_TX_STOP: begin
          if (st_reg.tx_ovs == fmsp_pkg::OVS_LAST) begin
            st_next.tx_st = fmsp_pkg::FMSP_TX_IDLE;
          end
        end
        default: st_next.tx_st = fmsp_pkg::FMSP_TX_IDLE;
      endcase
    end

    // ==========================================================
    // Receiver
    if (tick) begin
      st_next.rx_ovs = st_reg.rx_ovs + 4'h1;
      case (st_reg.rx_st)
        fmsp_pkg::FMSP_RX_IDLE: begin
          st_next.rx_ovs = 4'h0;
          st_next.rx_bit = fmsp_pkg::BIT_ZERO;
          if (st_reg.ctrl_high[fmsp_pkg::H_RE]) begin
            if (mode == fmsp_pkg::FMSP_MODE_SHIFT) begin
              // Mode 0 receive owns the shift clock while idle otherwise
              if (!st_reg.ctrl_high[fmsp_pkg::H_RIP] &&
                  st_reg.tx_st == fmsp_pkg::FMSP_TX_IDLE) begin
                st_next.rx_st = fmsp_pkg::FMSP_RX_SHIFT;
              end
            end else if (!rx_in) begin
              st_next.rx_st = fmsp_pkg::FMSP_RX_START;
            end
          end
        end
        fmsp_pkg::FMSP_RX_START: begin
          if (st_reg.rx_ovs == fmsp_pkg::OVS_MID) begin
            // A glitch shorter than half a bit is dropped
            if (rx_in) begin
              st_next.rx_st = fmsp_pkg::FMSP_RX_IDLE;
            end else begin
              st_next.rx_st = fmsp_pkg::FMSP_RX_DATA;
              st_next.rx_ovs = 4'h0;
            end
          end
        end
        fmsp_pkg::FMSP_RX_DATA: begin
          if (st_reg.rx_ovs == fmsp_pkg::OVS_LAST) begin
            st_next.rx_sh = {rx_in, st_reg.rx_sh[7:1]};
            st_next.rx_bit = st_reg.rx_bit + 4'h1;
            if (st_reg.rx_bit == fmsp_pkg::LAST_DATA) begin
              st_next.rx_st = (mode == fmsp_pkg::FMSP_MODE_A8) ?
                fmsp_pkg::FMSP_RX_STOP : fmsp_pkg::FMSP_RX_NINTH;
            end
          end
        end
        fmsp_pkg::FMSP_RX_NINTH: begin
          if (st_reg.rx_ovs == fmsp_pkg::OVS_LAST) begin
            // Held byte is overwritten if still unread
            st_next.rx_st = fmsp_pkg::FMSP_RX_IDLE;
            st_next.rx_buf = st_reg.rx_sh;
            st_next.ctrl_high[fmsp_pkg::H_RB8] = rx_in;
            if (!(st_reg.ctrl_high[fmsp_pkg::H_MCE] && !rx_in)) begin
              st_next.ctrl_high[fmsp_pkg::H_RIP] = 1'b1;
            end
          end
        end
        fmsp_pkg::FMSP_RX_STOP: begin
          if (st_reg.rx_ovs == fmsp_pkg::OVS_LAST) begin
            st_next.rx_st = fmsp_pkg::FMSP_RX_IDLE;
            st_next.rx_buf = st_reg.rx_sh;
            // With multiprocessor enable, a bad stop bit raises no flag
            if (!(st_reg.ctrl_high[fmsp_pkg::H_MCE] && !rx_in)) begin
              st_next.ctrl_high[fmsp_pkg::H_RIP] = 1'b1;
            end
          end
        end
        fmsp_pkg::FMSP_RX_SHIFT: begin
          if (st_reg.rx_ovs == fmsp_pkg::SCK_FALL) begin
            st_next.sck = 1'b0;
          end else if (st_reg.rx_ovs == fmsp_pkg::SCK_RISE) begin
            st_next.sck = 1'b1;
            st_next.rx_sh = {rx_in, st_reg.rx_sh[7:1]};
            st_next.rx_bit = st_reg.rx_bit + 4'h1;
          end else if (st_reg.rx_ovs == fmsp_pkg::OVS_LAST &&
                       st_reg.rx_bit == fmsp_pkg::NINTH) begin
            st_next.rx_st = fmsp_pkg::FMSP_RX_IDLE;
            st_next.rx_buf = st_reg.rx_sh;
            st_next.ctrl_high[fmsp_pkg::H_RIP] = 1'b1;
          end
        end
        default: st_next.rx_st = fmsp_pkg::FMSP_RX_IDLE;
      endcase
    end
    if (mode != fmsp_pkg::FMSP_MODE_SHIFT) begin
      st_next.sck = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_reg <= '0;
      st_reg.ctrl_high <= fmsp_pkg::CTRL_RESET;
      st_reg.ctrl_low <= fmsp_pkg::CTRL_RESET;
      st_reg.baud_divisor <= fmsp_pkg::BAUD_RESET;
      st_reg.tx_st <= fmsp_pkg::FMSP_TX_IDLE;
      st_reg.rx_st <= fmsp_pkg::FMSP_RX_IDLE;
      st_reg.tx_out <= 1'b1;
      st_reg.sck <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rdata = st_reg.rdata;
  assign o_serial_rx_pin = st_reg.rx_dout;
  assign o_serial_rx_pin_oe = st_reg.rx_oe;
  // Shift clock replaces serial data on the transmit pin in mode 0
  assign o_serial_tx_pin = (mode == fmsp_pkg::FMSP_MODE_SHIFT) ? st_reg.sck : st_reg.tx_out;
  assign o_rx_irq = st_reg.ctrl_high[fmsp_pkg::H_RIP] &&
    st_reg.ctrl_high[fmsp_pkg::H_RIE];
  assign o_tx_irq = st_reg.ctrl_low[fmsp_pkg::L_TIP] &&
    st_reg.ctrl_low[fmsp_pkg::L_TIE];
  assign o_clock_select = st_reg.ctrl_low[fmsp_pkg::L_CLK_HI:fmsp_pkg::L_CLK_LO];
endmodule // fmsp_port

/* File: bench/fmsp_port_asserts.sv */
// Purpose: Port-level checks for the four-mode serial port.
// Assumes: Settings are shadowed from register writes seen at the port.
// Notes: Bit lengths allow one clock of slip, as a frame may start between ticks.
`timescale 1ns/1ns
module fmsp_port_asserts (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Serial pins
  input wire logic i_serial_rx_pin,
  input wire logic o_serial_rx_pin,
  input wire logic o_serial_rx_pin_oe,
  input wire logic o_serial_tx_pin,
  // Requests and clock source
  input wire logic o_rx_irq,
  input wire logic o_tx_irq,
  input wire logic [1:0] o_clock_select
);
  // ==========
  // Shadow settings
  logic wr_high, wr_low, tie_reg, rie_reg;
  logic [1:0] mode_reg, sel_reg;
  logic [7:0] div_reg;
  int low_reg, bit_len, half_len;
  assign wr_high = i_wr && (i_addr == 8'h14);
  assign wr_low = i_wr && (i_addr == 8'h15);
  assign bit_len = (mode_reg == 2'h2) ? 16 : 16 * (int'(div_reg) + 1);
  assign half_len = 8 * (int'(div_reg) + 1);
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mode_reg <= 2'h0;
      sel_reg <= 2'h0;
      div_reg <= 8'h00;
      tie_reg <= 1'b0;
      rie_reg <= 1'b0;
    end else begin
      if (wr_high) begin
        mode_reg <= i_wdata[7:6];
        rie_reg <= i_wdata[1];
      end
      if (wr_low) begin
        sel_reg <= i_wdata[3:2];
        tie_reg <= i_wdata[1];
      end
      if (i_wr && (i_addr == 8'h17)) begin
        div_reg <= i_wdata;
      end
    end
    low_reg <= o_serial_tx_pin ? 0 : low_reg + 1;
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  // ==========
  // Checks
  a_reset_quiet: assert property (
    $fell(i_srst) |-> !o_tx_irq && !o_rx_irq && o_clock_select == 2'h0 && o_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  a_oe_mode_zero: assert property (
    o_serial_rx_pin_oe |-> mode_reg == 2'h0)
    else $error("receive pin driven outside shift mode");
  a_clock_source: assert property (
    wr_low |=> o_clock_select == sel_reg)
    else $error("clock source select differs from write");
  a_tx_irq_gate: assert property (
    !tie_reg && !$past(tie_reg) |-> !o_tx_irq)
    else $error("transmit request while disabled");
  a_rx_irq_gate: assert property (
    !rie_reg && !$past(rie_reg) |-> !o_rx_irq)
    else $error("receive request while disabled");
  a_tx_flag_held: assert property (
    $fell(o_tx_irq) |-> $past(wr_low) || $past(wr_low, 2) || $past(i_srst) || $past(i_srst, 2))
    else $error("transmit request dropped without a write");
  a_rx_flag_held: assert property (
    $fell(o_rx_irq) |-> $past(wr_high) || $past(wr_high, 2) || $past(i_srst) || $past(i_srst, 2))
    else $error("receive request dropped without a write");
  a_read_data_slot: assert property (
    o_rdata != 8'h00 |-> $past(i_rd))
    else $error("read data outside its slot");
  a_async_bit_len: assert property (
    $rose(o_serial_tx_pin) && mode_reg != 2'h0 |-> ((low_reg + 1) % bit_len) <= 1)
    else $error("low run not a whole number of bits");
  a_sck_low_half: assert property (
    $rose(o_serial_tx_pin) && mode_reg == 2'h0 |-> low_reg + 1 >= half_len && low_reg <= half_len)
    else $error("shift clock low phase wrong length");
  a_data_at_rise: assert property (
    $rose(o_serial_tx_pin) && o_serial_rx_pin_oe |-> $stable(o_serial_rx_pin))
    else $error("receive pin data changed at rising shift clock");
endmodule // fmsp_port_asserts

bind fmsp_port fmsp_port_asserts u_asserts (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_serial_rx_pin(i_serial_rx_pin), .o_serial_rx_pin(o_serial_rx_pin),
  .o_serial_rx_pin_oe(o_serial_rx_pin_oe), .o_serial_tx_pin(o_serial_tx_pin),
  .o_rx_irq(o_rx_irq), .o_tx_irq(o_tx_irq), .o_clock_select(o_clock_select));

/* File: bench/fmsp_remote.sv */
// Purpose: Far-side device: async transceiver and shift-mode peripheral.
// Assumes: Receive line idles high, as a pulled-up line would.
// Notes: Bit time is given per call, so fast and slow partners share one model.
`timescale 1ns/1ns
module fmsp_remote (
  // Clock
  input wire logic i_clock,
  // Lines
  input wire logic i_tx_line,
  input wire logic i_rx_wire,
  output logic o_rx_drive
);
  initial o_rx_drive = 1'b1;
  // ==========
  // Async frame out, low start then data least significant first
  task automatic send(input logic [8:0] v, input int nb, input int cpb);
    o_rx_drive <= 1'b0;
    repeat (cpb) @(posedge i_clock);
    for (int i = 0; i < nb; i++) begin
      o_rx_drive <= v[i];
      repeat (cpb) @(posedge i_clock);
    end
    o_rx_drive <= 1'b1;
    repeat (cpb) @(posedge i_clock);
  endtask
  // Async frame in, sampled mid-bit; stop bit lands above the data
  task automatic capture(input int nb, input int cpb, output logic [9:0] v);
    v = 10'h000;
    @(negedge i_tx_line);
    repeat (cpb / 2) @(posedge i_clock);
    for (int i = 0; i <= nb; i++) begin
      repeat (cpb) @(posedge i_clock);
      v[i] = i_tx_line;
    end
  endtask
  // Shift mode: take data on the rising shift clock
  task automatic m0_take(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_tx_line);
      v[i] = i_rx_wire;
    end
  endtask
  // Shift mode: change data on the falling shift clock
  task automatic m0_give(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(negedge i_tx_line);
      o_rx_drive <= v[i];
      @(posedge i_tx_line);
    end
    o_rx_drive <= 1'b1;
  endtask
endmodule // fmsp_remote

/* File: bench/fmsp_port_tb_top.sv */
// Purpose: Self-checking bench for the four-mode serial port.
// Assumes: Divisor 0 or 1, so a bit lasts 16 or 32 clocks.
// Notes: Registers are reached over the one-cycle strobe port.
`timescale 1ns/1ns
module fmsp_port_tb_top;
  logic clk, srst, wr, rd, rx_out, rx_oe, tx_pin, rx_irq, tx_irq, drive, rx_wire;
  logic [7:0] addr, wdata, rdata, d;
  logic [1:0] csel;
  logic [9:0] got;
  int mismatches, total_checks, n;
  assign rx_wire = rx_oe ? rx_out : drive;
  fmsp_port u_dut (.i_clock(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_serial_rx_pin(rx_wire), .o_serial_rx_pin(rx_out),
    .o_serial_rx_pin_oe(rx_oe), .o_serial_tx_pin(tx_pin), .o_rx_irq(rx_irq),
    .o_tx_irq(tx_irq), .o_clock_select(csel));
  fmsp_remote u_far (.i_clock(clk), .i_tx_line(tx_pin), .i_rx_wire(rx_wire),
    .o_rx_drive(drive));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========
  // Access and compare tasks
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input string what, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, {2'h0, rdata}, {2'h0, v});
  endtask
  // Start a transmit by a data write while the far side listens
  task automatic xmit(input int nb, input int cpb, input logic [7:0] v, input logic [9:0] e);
    fork
      u_far.capture(nb, cpb, got);
      wreg(8'h16, v);
    join
    // Let the stop bit run out so the next frame does not cut it short
    repeat (cpb / 2) @(posedge clk);
    chk("frame", got, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  // ==========
  // Tests
  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rreg("ctrl_high", 8'h14, 8'h00);
    rreg("ctrl_low", 8'h15, 8'h00);
    rreg("unmapped", 8'h20, 8'h00);
    wreg(8'h15, 8'h0e);
    rreg("ctrl_low", 8'h15, 8'h0e);
    chk("clock_select", {8'h00, csel}, 10'h003);
    wreg(8'h17, 8'h01);
    rreg("baud", 8'h17, 8'h01);
    $display("test registers done");
    wreg(8'h14, 8'h40);
    xmit(8, 32, 8'h35, 10'h135);
    rreg("ctrl_low", 8'h15, 8'h0f);
    chk("tx_irq", {9'h000, tx_irq}, 10'h001);
    wreg(8'h15, 8'h0e);
    rreg("ctrl_low", 8'h15, 8'h0e);
    chk("tx_irq", {9'h000, tx_irq}, 10'h000);
    $display("test mode 1 transmit done");
    wreg(8'h14, 8'h52);
    u_far.send(9'h0c3, 8, 32);
    rreg("ctrl_high", 8'h14, 8'h53);
    chk("rx_irq", {9'h000, rx_irq}, 10'h001);
    rreg("data", 8'h16, 8'hc3);
    u_far.send(9'h03c, 8, 32);
    u_far.send(9'h0a5, 8, 32);
    rreg("data", 8'h16, 8'ha5);
    wreg(8'h14, 8'h42);
    u_far.send(9'h099, 8, 32);
    rreg("ctrl_high", 8'h14, 8'h42);
    $display("test mode 1 receive done");
    wreg(8'h14, 8'h88);
    xmit(9, 16, 8'ha9, 10'h3a9);
    wreg(8'h15, 8'h82);
    wreg(8'h14, 8'hc0);
    xmit(9, 32, 8'h07, 10'h307);
    wreg(8'h15, 8'h02);
    wreg(8'h14, 8'hf2);
    u_far.send(9'h011, 9, 32);
    rreg("ctrl_high", 8'h14, 8'hf2);
    u_far.send(9'h1e4, 9, 32);
    rreg("ctrl_high", 8'h14, 8'hf7);
    rreg("data", 8'h16, 8'he4);
    $display("test nine bit modes done");
    wreg(8'h17, 8'h00);
    wreg(8'h14, 8'h00);
    fork
      u_far.m0_take(d);
      wreg(8'h16, 8'ha6);
    join
    chk("shift out", {2'h0, d}, 10'h0a6);
    repeat (16) @(posedge clk);
    rreg("ctrl_low", 8'h15, 8'h03);
    fork
      u_far.m0_give(8'h5b);
      wreg(8'h14, 8'h12);
    join
    repeat (16) @(posedge clk);
    rreg("ctrl_high", 8'h14, 8'h13);
    rreg("data", 8'h16, 8'h5b);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      n += (tx_pin === 1'b0) ? 1 : 0;
    end
    chk("clock held", n[9:0], 10'h000);
    $display("test shift mode done");
    report_and_stop();
  end
endmodule // fmsp_port_tb_top
